/* src/serial_register_access.v */
// Serial command decoder with control and status register file
`timescale 1ns/1ps
`default_nettype none
`include "sra_map.vh"

module serial_register_access #(
  parameter [7:0] ID_VALUE = 8'h5A,  // Arbitrary identifier value
  parameter       NUM_STAT = 10,
  parameter       NUM_CTRL = 31
) (
  input  wire                    ref_clk,
  input  wire                    rst_b,
  input  wire                    sclk,
  input  wire                    chip_select_low,
  input  wire                    serial_in,
  output wire                    serial_out,
  output wire                    serial_out_en,
  input  wire [2:0]              device_mode,
  input  wire                    mode_change,
  input  wire [8*NUM_STAT-1:0]   status_set,
  input  wire [7:0]              wake_pin_level,
  input  wire                    fail_trigger,
  input  wire                    fail_release,
  input  wire [3:0]              switch_fail,
  output wire                    fail_output,
  output wire [3:0]              high_side_switch,
  output wire [7:0]              summary_field
);

  // Pin synchronisers: first stage only feeds the second
  reg  [2:0]  sclk_s_q;
  reg  [2:0]  cs_s_q;
  reg  [1:0]  sdi_s_q;
  reg  [7:0]  wk_s1_q;
  reg  [7:0]  wk_s2_q;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_s_q <= 3'b000;
      cs_s_q   <= 3'b111;
      sdi_s_q  <= 2'b00;
      wk_s1_q  <= 8'h00;
      wk_s2_q  <= 8'h00;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[1:0], chip_select_low};
      sdi_s_q  <= {sdi_s_q[0], serial_in};
      wk_s1_q  <= wake_pin_level;
      wk_s2_q  <= wk_s1_q;
    end
  end

  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire cs_fall   = ~cs_s_q[1] & cs_s_q[2];
  wire cs_rise   = cs_s_q[1] & ~cs_s_q[2];
  wire cs_active = ~cs_s_q[1];
  wire sdi_bit   = sdi_s_q[1];

  // Frame state
  reg  [15:0] rx_q;
  reg  [15:0] tx_q;
  reg  [4:0]  in_cnt_q;
  reg  [4:0]  out_cnt_q;
  reg         sdo_q;
  reg         sdo_en_q;
  reg  [7:0]  summary_q;
  reg         fail_q;
  reg  [3:0]  hs_q;

  reg  [7:0]  ctrl_q [0:NUM_CTRL-1];
  reg  [7:0]  stat_q [0:NUM_STAT-1];
  reg  [7:0]  rd_data;

  // Address of the word being received, complete at the seventh sample
  wire [6:0]  rd_addr = {sdi_bit, rx_q[15:10]};

  // Whole command taken at chip select rise, only for a full word
  wire        restart = (device_mode == `MODE_RESTART);
  wire        exec    = cs_rise & (in_cnt_q == `FRAME_BITS) &
                        ~restart;
  wire [6:0]  cmd_addr = rx_q[6:0];
  wire        cmd_rw   = rx_q[`RW_BIT];
  wire [7:0]  cmd_data = rx_q[15:8];
  wire        ctrl_wr  = exec & cmd_rw &
                         (cmd_addr <= `CTRL_LAST);

  function [6:0] stat_addr;
    input integer idx;
    begin
      case (idx)
        0:       stat_addr = `ADDR_SUP_TWO;
        1:       stat_addr = `ADDR_SUP_ONE;
        2:       stat_addr = `ADDR_THERM;
        3:       stat_addr = `ADDR_DEV;
        4:       stat_addr = `ADDR_BUS_A;
        5:       stat_addr = `ADDR_BUS_B;
        6:       stat_addr = `ADDR_WAKE_A;
        7:       stat_addr = `ADDR_WAKE_B;
        8:       stat_addr = `ADDR_HS_OVL;
        default: stat_addr = `ADDR_HS_OPEN;
      endcase
    end
  endfunction

  // Sleep pushes an active transceiver setting back to wake capable
  function [1:0] trx_park;
    input [1:0] cur;
    begin
      if (cur == `TRX_OFF || cur == `TRX_WAKE)
        trx_park = cur;
      else
        trx_park = `TRX_WAKE;
    end
  endfunction

  // Read path, whole byte at a time
  integer k;
  always @* begin
    rd_data = 8'h00;
    if (rd_addr <= `CTRL_LAST) begin
      rd_data = ctrl_q[rd_addr[4:0]];
    end else if (rd_addr == `ADDR_WAKE_LVL) begin
      rd_data = wk_s2_q;
    end else if (rd_addr == `ADDR_IDENT) begin
      rd_data = ID_VALUE;
    end else begin
      for (k = 0; k < NUM_STAT; k = k + 1) begin
        if (rd_addr == stat_addr(k))
          rd_data = stat_q[k];
      end
    end
  end

  // Shift engine
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q      <= 16'h0000;
      tx_q      <= 16'h0000;
      in_cnt_q  <= 5'h00;
      out_cnt_q <= 5'h00;
      sdo_q     <= 1'b0;
      sdo_en_q  <= 1'b0;
    end else if (cs_fall) begin
      in_cnt_q  <= 5'h00;
      out_cnt_q <= 5'h00;
      tx_q      <= {8'h00, summary_q};
      sdo_q     <= summary_q[0];
      sdo_en_q  <= 1'b1;
    end else if (cs_rise) begin
      sdo_q     <= 1'b0;
      sdo_en_q  <= 1'b0;
    end else if (cs_active) begin
      if (sclk_fall) begin
        rx_q <= {sdi_bit, rx_q[15:1]};
        if (in_cnt_q != 5'h1F)
          in_cnt_q <= in_cnt_q + 5'h01;
        // Data byte goes out from bit 8, after the address is in
        if (in_cnt_q == 5'h06)
          tx_q[15:8] <= rd_data;
      end
      if (sclk_rise) begin
        if (out_cnt_q < 5'h0F) begin
          out_cnt_q <= out_cnt_q + 5'h01;
          sdo_q     <= tx_q[out_cnt_q[3:0] + 4'h1];
        end else begin
          sdo_q     <= 1'b0;
        end
      end
    end
  end

  // Control registers, host write first, then mode side effects
  integer c;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (c = 0; c < NUM_CTRL; c = c + 1)
        ctrl_q[c] <= `CTRL_RESET;
    end else begin
      // Enables are taken regardless of pending failure flags
      if (ctrl_wr)
        ctrl_q[cmd_addr[4:0]] <= cmd_data;
      if (mode_change) begin
        ctrl_q[`MODE_REG][`MODE_LSB+2:`MODE_LSB]
          <= device_mode;
        case (device_mode)
          `MODE_SLEEP: begin
            ctrl_q[`BUS_REG_A][1:0]
              <= trx_park(ctrl_q[`BUS_REG_A][1:0]);
            ctrl_q[`BUS_REG_B][1:0]
              <= trx_park(ctrl_q[`BUS_REG_B][1:0]);
          end
          `MODE_RESTART: begin
            ctrl_q[`HS_REG_A] <= 8'h00;
            ctrl_q[`HS_REG_B] <= 8'h00;
            ctrl_q[`MODE_REG][`SUPPLY_LSB+1:`SUPPLY_LSB]
              <= 2'b00;
            ctrl_q[`BUS_REG_A][1:0]
              <= trx_park(ctrl_q[`BUS_REG_A][1:0]);
            ctrl_q[`BUS_REG_B][1:0]
              <= trx_park(ctrl_q[`BUS_REG_B][1:0]);
          end
          // Stop leaves transceiver and switch settings alone; no
          // self-assignment here, it would swallow a same-cycle write
          default: begin
          end
        endcase
      end
      // Failure turns the switch off but raises no wake event
      if (switch_fail[0])
        ctrl_q[`HS_REG_A][3:0] <= 4'h0;
      if (switch_fail[1])
        ctrl_q[`HS_REG_A][7:4] <= 4'h0;
      if (switch_fail[2])
        ctrl_q[`HS_REG_B][3:0] <= 4'h0;
      if (switch_fail[3])
        ctrl_q[`HS_REG_B][7:4] <= 4'h0;
    end
  end

  // Status registers: hardware set beats a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < NUM_STAT; g = g + 1) begin : g_stat
      wire clr = exec & cmd_rw & (cmd_addr == stat_addr(g));
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          stat_q[g] <= 8'h00;
        end else begin
          // Diagnosis survives every mode change
          stat_q[g] <= (stat_q[g] & {8{~clr}}) |
                       status_set[8*g +: 8];
        end
      end
    end
  endgenerate

  // Switch drive follows the configured nibble per output
  genvar h;
  generate
    for (h = 0; h < 4; h = h + 1) begin : g_hs
      wire [7:0] src = (h < 2) ? ctrl_q[`HS_REG_A] : ctrl_q[`HS_REG_B];
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
          hs_q[h] <= 1'b0;
        else
          hs_q[h] <= |src[4*(h%2) +: 4];
      end
    end
  endgenerate

  // Summary field and fail output
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      summary_q <= 8'h00;
      fail_q    <= 1'b0;
    end else begin
      summary_q[0] <= |stat_q[1];
      summary_q[1] <= |stat_q[2];
      summary_q[2] <= |stat_q[3];
      summary_q[3] <= |(stat_q[4] | stat_q[5]);
      summary_q[4] <= |(stat_q[6] | stat_q[7]);
      summary_q[5] <= |stat_q[0];
      summary_q[6] <= |stat_q[8];
      summary_q[7] <= |stat_q[9];
      // Only released from normal mode; low power and restart hold it
      if (fail_trigger)
        fail_q <= 1'b1;
      else if (fail_release && device_mode == `MODE_NORMAL)
        fail_q <= 1'b0;
    end
  end

  assign serial_out       = sdo_q;
  assign serial_out_en    = sdo_en_q;
  assign fail_output      = fail_q;
  assign high_side_switch = hs_q;
  assign summary_field    = summary_q;

endmodule
`default_nettype wire

/* src/sra_map.vh */
// Command word layout, register map and mode codes for the serial access
// Operation
// - Command bits 6..0 hold the seven-bit register address.
// - Command bits 15..8 hold the eight-bit data byte.
// - Every write, clear and read acts on a whole byte.
// - Status bits clear only on an explicit clearing command from the host.
// - In restart mode received commands are ignored and registers untouched.
// - Status access returns the addressed content in the same frame.
// - Control read shows old byte; a write shows after chip select rises.
// - Every response carries an eight-bit status summary field.
// - Summary bit is one while any bit of its register is set.
// - Summary bits 0..2 follow supply one, thermal and device status.
// - Summary bit 3 ORs both bus registers, bit 4 both wake registers.
// - Summary bits 5..7 follow supply two, switch overload and open load.
// - Wake pin level register has no summary bit.
// - Control registers 0x00..0x1E: bit 7 set writes, clear only reads.
// - Status registers 0x40..0x7E: bit 7 set clears after reporting.
// - Wake pin level and identification registers ignore clear requests.
// - Driver enables are accepted while failure flags remain set.
// - On a mode change the mode field shows the mode entered.
// - Stop or sleep keeps diagnosis bits and a triggered fail output.
// - Stop keeps transceiver bits; sleep parks active transceiver settings.
// - Switches stay on in low power; a failure turns one off silently.
// - Restart clears switch and supply configuration, keeps fail output.
// - Sixteen-bit word shifted under chip select low, used after it rises.
// - Input sampled on falling edges, output shifted after rising edges.
`ifndef SRA_MAP_VH
`define SRA_MAP_VH
`define FRAME_BITS       16
`define RW_BIT           7
`define CTRL_LAST        7'h1E
`define STAT_FIRST       7'h40
`define CTRL_RESET       8'h00
`define MODE_REG         5'h01
`define MODE_LSB         0
`define SUPPLY_LSB       4
`define BUS_REG_A        5'h04
`define BUS_REG_B        5'h05
`define HS_REG_A         5'h14
`define HS_REG_B         5'h15
`define TRX_OFF          2'b00
`define TRX_WAKE         2'b01
`define ADDR_SUP_TWO     7'h40
`define ADDR_SUP_ONE     7'h41
`define ADDR_THERM       7'h42
`define ADDR_DEV         7'h43
`define ADDR_BUS_A       7'h44
`define ADDR_BUS_B       7'h45
`define ADDR_WAKE_A      7'h46
`define ADDR_WAKE_B      7'h47
`define ADDR_WAKE_LVL    7'h48
`define ADDR_HS_OVL      7'h54
`define ADDR_HS_OPEN     7'h55
`define ADDR_IDENT       7'h7E
`define MODE_NORMAL      3'b000
`define MODE_SLEEP       3'b001
`define MODE_STOP        3'b010
`define MODE_RESTART     3'b011
`endif

/* verif/host_model.sv */
// Host master model that shifts frames over the serial link
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output var logic sclk,
  output var logic chip_select_low,
  output var logic serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b0;
  end
  // Clock stands low outside frames; a short count is allowed on purpose
  task automatic frame(input logic [15:0] c, input int n,
                       output logic [15:0] r);
    r = 16'h0000;
    chip_select_low = 1'b0;
    serial_in = c[0];
    #62.5;
    for (int k = 0; k < n; k++) begin
      r[k] = serial_out & serial_out_en;
      sclk = 1'b1;
      #1;
      // Bit k goes out after rising edge k+1, sampled on falling k+1
      serial_in = c[k];
      #61.5;
      sclk = 1'b0;
      #62.5;
    end
    chip_select_low = 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    serial_in = ~serial_in;
    #62.5;
  endtask
endmodule
`default_nettype wire

/* verif/sra_chk.sv */
// Port-level checks for the serial register access block
`timescale 1ns/1ps
`default_nettype none
module sra_chk #(
  parameter NUM_STAT = 10
) (
  input wire logic                  ref_clk,
  input wire logic                  rst_b,
  input wire logic                  chip_select_low,
  input wire logic                  serial_out_en,
  input wire logic [2:0]            device_mode,
  input wire logic                  mode_change,
  input wire logic [8*NUM_STAT-1:0] status_set,
  input wire logic [3:0]            switch_fail,
  input wire logic                  fail_output,
  input wire logic [3:0]            high_side_switch,
  input wire logic [7:0]            summary_field
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Set lands one edge after the pulse, the summary one edge later
  sequence s_out_on;
    ##[2:6] serial_out_en;
  endsequence
  sequence s_hs_off;
    ##[1:3] (high_side_switch == 4'h0);
  endsequence
  a_sum_supply_two: assert property (
    |status_set[7:0] |-> ##2 summary_field[5]) else $error("sum bit5");
  a_sum_supply_one: assert property (
    |status_set[15:8] |-> ##2 summary_field[0]) else $error("sum bit0");
  a_sum_bus_pair: assert property (
    |status_set[47:32] |-> ##2 summary_field[3]) else $error("sum bit3");
  a_sum_wake_pair: assert property (
    |status_set[63:48] |-> ##2 summary_field[4]) else $error("sum bit4");
  a_sum_open_load: assert property (
    |status_set[79:72] |-> ##2 summary_field[7]) else $error("sum bit7");
  a_out_en_idle: assert property (
    chip_select_low [*6] |-> !serial_out_en) else $error("out enable idle");
  a_out_en_start: assert property (
    $fell(chip_select_low) |-> s_out_on) else $error("out enable late");
  a_fail_stays_on: assert property (
    fail_output && device_mode != 3'h0 |=> fail_output)
    else $error("fail output dropped");
  a_restart_hs_off: assert property (
    mode_change && device_mode == 3'h3 |-> s_hs_off)
    else $error("switch kept in restart");
  a_switch_trip_off: assert property (
    switch_fail[1] |-> ##[1:3] !high_side_switch[1])
    else $error("switch kept on fault");
endmodule
bind serial_register_access sra_chk #(.NUM_STAT(NUM_STAT)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .chip_select_low(chip_select_low),
  .serial_out_en(serial_out_en), .device_mode(device_mode),
  .mode_change(mode_change), .status_set(status_set),
  .switch_fail(switch_fail), .fail_output(fail_output),
  .high_side_switch(high_side_switch), .summary_field(summary_field));
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the serial register access block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary identifier
  logic        ref_clk = 1'b0, rst_b = 1'b0, mode_change = 1'b0;
  logic        fail_trigger = 1'b0, fail_release = 1'b0;
  logic [2:0]  device_mode = 3'h0;
  logic [79:0] status_set = '0;
  logic [7:0]  wake_pin_level = 8'h00, es = 8'h00;
  logic [3:0]  switch_fail = 4'h0;
  logic [15:0] r;
  wire         sclk, chip_select_low, serial_in, serial_out;
  wire         serial_out_en, fail_output;
  wire [3:0]   high_side_switch;
  wire [7:0]   summary_field;
  int          n_errors = 0, checks = 0;
  logic [2:0]  smap [10] = '{3'h5, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3,
                             3'h4, 3'h4, 3'h6, 3'h7};
  logic [6:0]  amap [10] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45,
                             7'h46, 7'h47, 7'h54, 7'h55};
  serial_register_access #(.ID_VALUE(ID)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
    .chip_select_low(chip_select_low), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en),
    .device_mode(device_mode), .mode_change(mode_change),
    .status_set(status_set), .wake_pin_level(wake_pin_level),
    .fail_trigger(fail_trigger), .fail_release(fail_release),
    .switch_fail(switch_fail), .fail_output(fail_output),
    .high_side_switch(high_side_switch), .summary_field(summary_field));
  host_model host (
    .sclk(sclk), .chip_select_low(chip_select_low),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en));
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Summary expectation es is tracked by the bench across frames
  task automatic x(input [6:0] a, input w, input [7:0] d, input [7:0] ed);
    host.frame({d, w, a}, 16, r);
    chk(r[7:0], es);
    chk(r[15:8], ed);
  endtask
  task automatic md(input [2:0] m);
    tick(1);
    device_mode = m;
    mode_change = 1'b1;
    tick(1);
    mode_change = 1'b0;
    tick(3);
  endtask
  task automatic fp(input logic t);
    tick(1);
    fail_trigger = t;
    fail_release = !t;
    tick(1);
    fail_trigger = 1'b0;
    fail_release = 1'b0;
    tick(2);
  endtask
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    end_of_test;
  end
  initial begin
    tick(12);
    rst_b = 1'b1;
    tick(6);
    x(7'h01, 1'b0, 8'h00, 8'h00);
    for (int g = 0; g < 10; g++) begin
      tick(1);
      status_set[8*g + g%8] = 1'b1;
      tick(1);
      status_set = '0;
      tick(3);
      es[smap[g]] = 1'b1;
      x(amap[g], 1'b0, 8'h00, 8'h01 << (g%8));
    end
    x(7'h41, 1'b1, 8'h00, 8'h02);
    es[0] = 1'b0;
    x(7'h41, 1'b0, 8'h00, 8'h00);
    x(7'h44, 1'b1, 8'h00, 8'h10);
    x(7'h45, 1'b1, 8'h00, 8'h20);
    es[3] = 1'b0;
    chk(summary_field, es);
    wake_pin_level = 8'hA5;
    x(7'h48, 1'b1, 8'h00, 8'hA5);
    x(7'h48, 1'b0, 8'h00, 8'hA5);
    x(7'h7E, 1'b1, 8'h00, ID);
    x(7'h7E, 1'b0, 8'h00, ID);
    x(7'h14, 1'b1, 8'h21, 8'h00);
    x(7'h14, 1'b0, 8'hFF, 8'h21);
    host.frame(16'hFF94, 15, r);
    x(7'h14, 1'b0, 8'h00, 8'h21);
    chk({4'h0, high_side_switch}, 8'h03);
    tick(1);
    switch_fail = 4'h2;
    tick(1);
    switch_fail = 4'h0;
    tick(3);
    chk({4'h0, high_side_switch}, 8'h01);
    x(7'h14, 1'b0, 8'h00, 8'h01);
    x(7'h01, 1'b1, 8'h30, 8'h00);
    x(7'h04, 1'b1, 8'h02, 8'h00);
    x(7'h05, 1'b1, 8'h01, 8'h00);
    fp(1'b1);
    md(3'h1);
    x(7'h04, 1'b0, 8'h00, 8'h01);
    x(7'h05, 1'b0, 8'h00, 8'h01);
    x(7'h01, 1'b0, 8'h00, 8'h31);
    chk({4'h0, high_side_switch}, 8'h01);
    fp(1'b0);
    chk({7'h00, fail_output}, 8'h01);
    x(7'h04, 1'b1, 8'h02, 8'h01);
    md(3'h2);
    x(7'h04, 1'b0, 8'h00, 8'h02);
    x(7'h01, 1'b0, 8'h00, 8'h32);
    md(3'h3);
    host.frame(16'h7782, 16, r);
    md(3'h0);
    x(7'h02, 1'b0, 8'h00, 8'h00);
    x(7'h14, 1'b0, 8'h00, 8'h00);
    x(7'h01, 1'b0, 8'h00, 8'h00);
    chk({7'h00, fail_output}, 8'h01);
    fp(1'b0);
    chk({7'h00, fail_output}, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
